// ==== hdl/vip_regs.svh ====
// Constants of the vectored interrupt priority block: vector numbers,
// level codes, widths and reset values.
// Assumes it is included by the package and the design files by bare name.
//
// Operation
// RULE_01 - Higher levels always win over lower levels.
// RULE_02 - Equal level: smallest vector number wins.
// RULE_03 - Programmable sources take their configured level.
// RULE_04 - Fetch address is base plus twice vector.
// RULE_05 - Vector base resets to zero; reset vectors.
// RULE_06 - Vectors 2 to 5 fixed at level 3.
// RULE_07 - Debug vectors 6-10 programmable, levels 1-3.
// RULE_08 - Peripheral vectors 16-44 programmable, levels 0-2.
// RULE_09 - Flash module requests on vectors 18-20.
// RULE_10 - Serial peripheral requests on vectors 26, 27.
// RULE_11 - Async serial port requests on vectors 28-32.
// RULE_12 - Converter and PWM requests on vectors 40-44.
// RULE_13 - Vector 45 at level -1, lowest of all.
// RULE_14 - Reserved vectors never presented as requests.
// RULE_15 - Soft interrupts, ports, I2C, timers placed.
`ifndef VIP_REGS_SVH
`define VIP_REGS_SVH

`define VIP_NUM_VEC 46
`define VIP_VEC_W 6
`define VIP_REACH_W 19
`define VIP_LVL_W 3
`define VIP_CFG_W 2
`define VIP_BASE_RESET 19'h00000

// Level codes: the documented level plus one, so level -1 is code 0.
`define VIP_LVL_LOW 3'h0
`define VIP_LVL_0 3'h1
`define VIP_LVL_1 3'h2
`define VIP_LVL_2 3'h3
`define VIP_LVL_3 3'h4

`define VIP_VEC_RESET 6'h00
`define VIP_VEC_WATCHDOG 6'h01
`define VIP_VEC_CORE_FIRST 6'h02
`define VIP_NUM_CORE 4
`define VIP_VEC_DEBUG_FIRST 6'h06
`define VIP_NUM_DEBUG 5
`define VIP_VEC_SOFT2 6'h0b
`define VIP_VEC_SOFT1 6'h0c
`define VIP_VEC_SOFT0 6'h0d
`define VIP_VEC_PERIPH_FIRST 6'h10
`define VIP_NUM_PERIPH 29
`define VIP_VEC_POWER_SENSE 6'h10
`define VIP_VEC_CLOCK_SYNTH 6'h11
`define VIP_VEC_FLASH_FIRST 6'h12
`define VIP_VEC_PORT_FIRST 6'h16
`define VIP_VEC_SPI_RX 6'h1a
`define VIP_VEC_SPI_TX 6'h1b
`define VIP_VEC_ASP_TX_EMPTY 6'h1c
`define VIP_VEC_ASP_TX_IDLE 6'h1d
`define VIP_VEC_ASP_RX_ERROR 6'h1f
`define VIP_VEC_ASP_RX_FULL 6'h20
`define VIP_VEC_I2C 6'h23
`define VIP_VEC_TIMER_FIRST 6'h24
`define VIP_VEC_CONV_A 6'h28
`define VIP_VEC_CONV_B 6'h29
`define VIP_VEC_CONV_LIMIT 6'h2a
`define VIP_VEC_PWM_RELOAD 6'h2b
`define VIP_VEC_PWM_FAULT 6'h2c
`define VIP_VEC_SOFT_LOW 6'h2d

// Vectors 14, 15, 21, 30, 33 and 34.
`define VIP_RSVD_MASK 46'h0006_4020_c000

`endif

// ==== hdl/vip_pkg.sv ====
// Types shared by the vectored interrupt priority block.
// Assumes vip_regs.svh is on the include path.
`include "vip_regs.svh"

package vip_pkg;

    typedef logic [`VIP_LVL_W-1:0] vip_level_t;
    typedef logic [`VIP_VEC_W-1:0] vip_vector_t;
    typedef logic [`VIP_REACH_W-1:0] vip_addr_t;
    typedef logic [`VIP_CFG_W-1:0] vip_cfg_t;

    typedef enum logic [0:0] {
        VIP_ARB = 1'b0,
        VIP_HOLD = 1'b1
    } vip_phase_t;

    // Interrupt sources, grouped by the unit that raises them.
    typedef struct packed {
        logic lowest_priority_soft_interrupt;
        logic pwm_fault;
        logic pwm_reload;
        logic converter_limit;
        logic converter_b;
        logic converter_a;
        logic [3:0] timer;
        logic i2c;
        logic async_tx_empty;
        logic async_tx_idle;
        logic async_rx_error;
        logic async_rx_full;
        logic spi_rx_full;
        logic spi_tx_empty;
        logic [3:0] port;
        logic [2:0] flash_module;
        logic clock_synth;
        logic power_sense;
        logic soft0;
        logic soft1;
        logic soft2;
        logic [`VIP_NUM_DEBUG-1:0] debug;
        logic [`VIP_NUM_CORE-1:0] core_exc;
    } vip_req_t;

    // Level settings: code 0 disables a source.
    typedef struct packed {
        vip_cfg_t [`VIP_NUM_PERIPH-1:0] periph;
        vip_cfg_t [`VIP_NUM_DEBUG-1:0] debug;
    } vip_cfg_set_t;

    typedef struct packed {
        logic valid;
        vip_vector_t vector;
        vip_level_t level;
        vip_addr_t fetch_addr;
    } vip_grant_t;

    typedef struct packed {
        vip_phase_t phase;
        vip_addr_t vector_base;
        vip_grant_t grant;
    } vip_state_t;

endpackage

// ==== hdl/vip_arbiter.sv ====
// Combinational arbiter: picks the active vector with the highest level,
// and among equals the lowest vector number.
// Assumes level codes grow with priority.
`timescale 1ns/100ps
`include "vip_regs.svh"

module vip_arbiter
    import vip_pkg::*;
#(
    parameter int NUM_VEC = `VIP_NUM_VEC
) (
    // Candidates
    input wire logic [NUM_VEC-1:0] active,
    input wire vip_level_t [NUM_VEC-1:0] level,
    // Winner
    output logic any,
    output vip_vector_t win_vector,
    output vip_level_t win_level
);

    logic [NUM_VEC-1:0][`VIP_LVL_W:0] key;

    genvar g;
    generate
        for (g = 0; g < NUM_VEC; g++) begin : g_key
            assign key[g] = {active[g], level[g]};
        end
    endgenerate

    // Scanning downward with >= lets a lower vector replace an equal one.
    always_comb begin
        logic [`VIP_LVL_W:0] best;
        best = '0;
        win_vector = '0;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (active[i] && key[i] >= best) begin // [RULE_01] [RULE_02]
                best = key[i];
                win_vector = vip_vector_t'(i);
            end
        end
        any = best[`VIP_LVL_W];
        win_level = best[`VIP_LVL_W-1:0];
    end

endmodule // vip_arbiter

// ==== hdl/vip_top.sv ====
// Vectored interrupt priority logic: maps source requests onto vector
// numbers and levels, arbitrates, and presents the winner with its
// vector fetch address to the processor core.
// Assumes all inputs are synchronous to clk; the core acknowledges a
// presented vector with a one-cycle pulse and clears the source itself.
`timescale 1ns/100ps
`include "vip_regs.svh"

module vip_top
    import vip_pkg::*;
#(
    parameter int NUM_VEC = `VIP_NUM_VEC
) (
    // Clock, reset and clock enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Interrupt sources
    input wire vip_req_t req,
    // Level settings of the programmable sources
    input wire vip_cfg_set_t cfg,
    // Vector base load
    input wire logic vector_base_wr,
    input wire vip_addr_t vector_base_wdata,
    output vip_addr_t vector_base,
    // Entry points of chip reset and watchdog reset
    output vip_addr_t reset_fetch_addr,
    output vip_addr_t watchdog_fetch_addr,
    // Grant towards the core
    output vip_grant_t grant,
    input wire logic irq_ack
);

    vip_state_t state_reg;
    vip_state_t state_next;

    logic [NUM_VEC-1:0] act_raw;
    logic [NUM_VEC-1:0] act;
    vip_level_t [NUM_VEC-1:0] lvl;
    logic win_any;
    vip_vector_t win_vector;
    vip_level_t win_level;

    // Sources with a fixed level or a fixed slot.
    always_comb begin
        act_raw = '0;
        lvl = '0;
        for (int i = 0; i < `VIP_NUM_CORE; i++) begin
            act_raw[`VIP_VEC_CORE_FIRST + i] = req.core_exc[i];
            lvl[`VIP_VEC_CORE_FIRST + i] = `VIP_LVL_3; // [RULE_06]
        end
        act_raw[`VIP_VEC_SOFT2] = req.soft2; // [RULE_15]
        lvl[`VIP_VEC_SOFT2] = `VIP_LVL_2;
        act_raw[`VIP_VEC_SOFT1] = req.soft1; // [RULE_15]
        lvl[`VIP_VEC_SOFT1] = `VIP_LVL_1;
        act_raw[`VIP_VEC_SOFT0] = req.soft0; // [RULE_15]
        lvl[`VIP_VEC_SOFT0] = `VIP_LVL_0;
        act_raw[`VIP_VEC_POWER_SENSE] = req.power_sense;
        act_raw[`VIP_VEC_CLOCK_SYNTH] = req.clock_synth; // [RULE_08]
        for (int i = 0; i < 3; i++) begin
            // Access error, command complete, buffers empty.
            act_raw[`VIP_VEC_FLASH_FIRST + i] = req.flash_module[i]; // [RULE_09]
        end
        for (int i = 0; i < 4; i++) begin
            // Port D first, port A last.
            act_raw[`VIP_VEC_PORT_FIRST + i] = req.port[i]; // [RULE_15]
            act_raw[`VIP_VEC_TIMER_FIRST + i] = req.timer[i]; // [RULE_15]
        end
        act_raw[`VIP_VEC_SPI_RX] = req.spi_rx_full; // [RULE_10]
        act_raw[`VIP_VEC_SPI_TX] = req.spi_tx_empty; // [RULE_10]
        act_raw[`VIP_VEC_ASP_TX_EMPTY] = req.async_tx_empty; // [RULE_11]
        act_raw[`VIP_VEC_ASP_TX_IDLE] = req.async_tx_idle; // [RULE_11]
        act_raw[`VIP_VEC_ASP_RX_ERROR] = req.async_rx_error; // [RULE_11]
        act_raw[`VIP_VEC_ASP_RX_FULL] = req.async_rx_full; // [RULE_11]
        act_raw[`VIP_VEC_I2C] = req.i2c; // [RULE_15]
        act_raw[`VIP_VEC_CONV_A] = req.converter_a; // [RULE_12]
        act_raw[`VIP_VEC_CONV_B] = req.converter_b; // [RULE_12]
        act_raw[`VIP_VEC_CONV_LIMIT] = req.converter_limit; // [RULE_12]
        act_raw[`VIP_VEC_PWM_RELOAD] = req.pwm_reload; // [RULE_12]
        act_raw[`VIP_VEC_PWM_FAULT] = req.pwm_fault; // [RULE_12]
        act_raw[`VIP_VEC_SOFT_LOW] = req.lowest_priority_soft_interrupt;
        lvl[`VIP_VEC_SOFT_LOW] = `VIP_LVL_LOW; // [RULE_13]
        // Programmable levels; a setting of zero disables the source.
        for (int i = 0; i < `VIP_NUM_DEBUG; i++) begin
            if (cfg.debug[i] == 2'h0) begin
                act_raw[`VIP_VEC_DEBUG_FIRST + i] = 1'b0;
            end else begin
                act_raw[`VIP_VEC_DEBUG_FIRST + i] = req.debug[i];
            end
            // Settings 1..3 give levels 1..3. [RULE_07] [RULE_03]
            lvl[`VIP_VEC_DEBUG_FIRST + i] =
                vip_level_t'({1'b0, cfg.debug[i]} + 3'h1);
        end
        for (int i = 0; i < `VIP_NUM_PERIPH; i++) begin
            if (cfg.periph[i] == 2'h0) begin
                act_raw[`VIP_VEC_PERIPH_FIRST + i] = 1'b0;
            end
            // Settings 1..3 give levels 0..2. [RULE_08] [RULE_03]
            lvl[`VIP_VEC_PERIPH_FIRST + i] = vip_level_t'({1'b0, cfg.periph[i]});
        end
    end

    // Reset entry slots and reserved slots never compete.
    assign act = act_raw & ~`VIP_RSVD_MASK & ~46'h3; // [RULE_14]

    vip_arbiter #(
        .NUM_VEC(NUM_VEC)
    ) u_arbiter (
        .active(act),
        .level(lvl),
        .any(win_any),
        .win_vector(win_vector),
        .win_level(win_level)
    );

    always_comb begin
        state_next = state_reg;
        if (vector_base_wr) begin
            state_next.vector_base = vector_base_wdata;
        end
        unique case (state_reg.phase)
            VIP_ARB: begin
                if (state_reg.grant.valid && irq_ack) begin
                    // The acked source needs a cycle to drop its request,
                    // otherwise it would be granted twice.
                    state_next.phase = VIP_HOLD;
                    state_next.grant.valid = 1'b0;
                end else begin
                    // Re-arbitrate every cycle so a later, stronger request
                    // still overtakes one that is not yet acknowledged.
                    state_next.grant.valid = win_any;
                    state_next.grant.vector = win_vector;
                    state_next.grant.level = win_level;
                    state_next.grant.fetch_addr = vip_addr_t'(
                        state_reg.vector_base
                        + {win_vector, 1'b0}); // [RULE_04]
                end
            end
            VIP_HOLD: begin
                state_next.phase = VIP_ARB;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg.phase <= VIP_ARB;
            state_reg.vector_base <= `VIP_BASE_RESET; // [RULE_05]
            state_reg.grant <= '0;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign vector_base = state_reg.vector_base;
    assign grant = state_reg.grant;
    assign reset_fetch_addr = state_reg.vector_base; // [RULE_05]
    assign watchdog_fetch_addr = vip_addr_t'(state_reg.vector_base
        + {`VIP_VEC_WATCHDOG, 1'b0}); // [RULE_05]

endmodule // vip_top

// ==== sim/vip_assertions.sv ====
// Port checks of the vectored interrupt priority top.
// Assumes one clock and a core that acks with one-cycle pulses.
`timescale 1ns/100ps
`include "vip_regs.svh"

module vip_assertions
    import vip_pkg::*;
#(
    parameter int NUM_VEC = `VIP_NUM_VEC
) (
    // Clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Sources and settings
    input wire vip_req_t req,
    input wire vip_cfg_set_t cfg,
    // Vector base
    input wire logic vector_base_wr,
    input wire vip_addr_t vector_base_wdata,
    input wire vip_addr_t vector_base,
    input wire vip_addr_t reset_fetch_addr,
    input wire vip_addr_t watchdog_fetch_addr,
    // Core side
    input wire vip_grant_t grant,
    input wire logic irq_ack
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_acked;
        grant.valid && irq_ack && ce;
    endsequence
    sequence s_blank;
        !grant.valid [*2];
    endsequence

    AST_FETCH: assert property (
        grant.valid && $past(ce) && $stable(vector_base) |->
        grant.fetch_addr ==
        vip_addr_t'(vector_base + {grant.vector, 1'b0}))
        else $error("fetch address off");
    AST_ENTRY: assert property (
        reset_fetch_addr == vector_base &&
        watchdog_fetch_addr == vip_addr_t'(vector_base + 19'h2))
        else $error("entry points off");
    AST_BASE_LOAD: assert property (
        vector_base_wr && ce |=> vector_base == $past(vector_base_wdata))
        else $error("base not loaded");
    AST_RSVD: assert property (
        grant.valid |-> grant.vector < NUM_VEC && !(grant.vector inside
        {6'h00, 6'h01, 6'h0e, 6'h0f, 6'h15, 6'h1e, 6'h21, 6'h22}))
        else $error("reserved vector granted");
    AST_CORE_LVL: assert property (
        grant.valid && grant.vector inside {[6'h02:6'h05]} |->
        grant.level == `VIP_LVL_3)
        else $error("core exception level off");
    AST_LOW_LVL: assert property (
        grant.valid && grant.vector == `VIP_VEC_SOFT_LOW |->
        grant.level == `VIP_LVL_LOW)
        else $error("lowest soft interrupt level off");
    AST_CORE_WINS: assert property (
        grant.valid && $past(ce) && $past(req.core_exc[0]) |->
        grant.vector == `VIP_VEC_CORE_FIRST)
        else $error("level 3 request lost");
    AST_ACK_BLANK: assert property (s_acked |=> s_blank)
        else $error("grant shown during ack hold");
endmodule // vip_assertions

bind vip_top vip_assertions #(.NUM_VEC(NUM_VEC)) u_chk (.clk(clk),
    .reset(reset), .ce(ce), .req(req), .cfg(cfg),
    .vector_base_wr(vector_base_wr), .vector_base_wdata(vector_base_wdata),
    .vector_base(vector_base), .reset_fetch_addr(reset_fetch_addr),
    .watchdog_fetch_addr(watchdog_fetch_addr), .grant(grant),
    .irq_ack(irq_ack));

// ==== sim/vip_core_model.sv ====
// Behavioural core: acks each shown vector after a set wait.
// Assumes the grant of vip_top on the same clock and reset.
`timescale 1ns/100ps

module vip_core_model
    import vip_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Grant and answer
    input wire vip_grant_t grant,
    input wire logic [3:0] ack_wait,
    output logic irq_ack
);
    logic [3:0] wait_cnt;

    // The pulse drops at the edge that takes it, so no grant is acked twice.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_ack <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (irq_ack || !grant.valid) begin
            irq_ack <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= ack_wait) begin
            irq_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // vip_core_model

// ==== sim/vip_top_tb.sv ====
// Testbench of the vectored interrupt priority top.
// Assumes the core model acks and this bench clears acked sources.
`timescale 1ns/100ps

module vip_top_tb;
    import vip_pkg::*;
    localparam logic [5:0] VEC [38] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
        6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h10, 6'h11, 6'h12,
        6'h13, 6'h14, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1b, 6'h1a, 6'h20, 6'h1f,
        6'h1d, 6'h1c, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2a,
        6'h2b, 6'h2c, 6'h2d};
    logic clk, reset, ce, vector_base_wr, irq_ack;
    logic [3:0] ack_wait;
    vip_req_t req;
    vip_cfg_set_t cfg;
    vip_addr_t vector_base_wdata, vector_base, base_exp;
    vip_addr_t reset_fetch_addr, watchdog_fetch_addr;
    vip_grant_t grant;
    vip_vector_t got[$];
    vip_addr_t got_fetch[$];
    int failures = 0;
    int n_checks = 0;

    vip_top DUT (.clk(clk), .reset(reset), .ce(ce), .req(req), .cfg(cfg),
        .vector_base_wr(vector_base_wr),
        .vector_base_wdata(vector_base_wdata), .vector_base(vector_base),
        .reset_fetch_addr(reset_fetch_addr),
        .watchdog_fetch_addr(watchdog_fetch_addr), .grant(grant),
        .irq_ack(irq_ack));
    vip_core_model u_core (.clk(clk), .reset(reset), .grant(grant),
        .ack_wait(ack_wait), .irq_ack(irq_ack));

    always #50 clk = ~clk;

    // A source drops its request at the edge the core takes its vector.
    always @(posedge clk) begin
        if (irq_ack && grant.valid) begin
            got.push_back(grant.vector);
            got_fetch.push_back(grant.fetch_addr);
            for (int b = 0; b < 38; b++) begin
                if (VEC[b] == grant.vector) req[b] <= 1'b0;
            end
        end
    end

    function automatic bit bad(input bit m);
        n_checks++;
        return m;
    endfunction

    task automatic miss(input string m);
        failures++;
        $display("MISMATCH %0t %s", $time, m);
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Level code of request bit b: documented level plus one, -1 if off.
    function automatic int lvl(input int b, input vip_cfg_set_t c);
        if (b < 4) return 4;
        if (b < 9) return c.debug[b-4] == 2'h0 ? -1 : c.debug[b-4] + 1;
        if (b < 12) return 12 - b;
        if (b == 37) return 0;
        return c.periph[VEC[b]-16] == 2'h0 ? -1 : int'(c.periph[VEC[b]-16]);
    endfunction

    function automatic vip_cfg_set_t pat(input int k, input int m);
        vip_cfg_set_t c;
        for (int i = 0; i < 5; i++) c.debug[i] = 2'((i + k) % m + 4 - m);
        for (int i = 0; i < 29; i++) c.periph[i] = 2'((i + k) % m + 4 - m);
        return c;
    endfunction

    task automatic start_and_freeze;
        @(negedge clk);
        if (bad(vector_base !== 19'h00000 || watchdog_fetch_addr !== 19'h00002
            || reset_fetch_addr !== 19'h00000)) miss("entry points");
        @(posedge clk);
        ce <= 1'b0;
        req.core_exc[1] <= 1'b1;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        @(negedge clk);
        if (bad(grant.valid !== 1'b0)) miss("grant while frozen");
        @(negedge clk);
        if (bad(grant.vector !== 6'h03 || grant.level !== 3'h4)) miss("core exception");
        if (bad(grant.fetch_addr !== 19'h00006)) miss("core fetch");
    endtask

    task automatic load_base(input vip_addr_t b);
        @(posedge clk);
        vector_base_wr <= 1'b1;
        vector_base_wdata <= b;
        base_exp = b;
        @(posedge clk);
        vector_base_wr <= 1'b0;
        @(negedge clk);
        if (bad(watchdog_fetch_addr !== vip_addr_t'(b + 19'h2) ||
            vector_base !== b || reset_fetch_addr !== b)) miss("base load");
    endtask

    // Raise every source at once and expect grants in level-then-vector order.
    task automatic run(input vip_cfg_set_t c, input logic [3:0] w);
        int n;
        int best;
        vip_vector_t exp_q[$];
        logic [37:0] on;
        on = '1;
        for (n = 0; n < 38; n++) if (lvl(n, c) < 0) on[n] = 1'b0;
        while (on != '0) begin
            best = -1;
            for (n = 0; n < 38; n++) begin
                if (on[n] && (best < 0 || lvl(n, c) > lvl(best, c) ||
                    (lvl(n, c) == lvl(best, c) && VEC[n] < VEC[best]))) best = n;
            end
            exp_q.push_back(VEC[best]);
            on[best] = 1'b0;
        end
        got = {};
        got_fetch = {};
        @(posedge clk);
        cfg <= c;
        ack_wait <= w;
        req <= '1;
        for (n = 0; n < 1000 && got.size() < exp_q.size(); n++) @(posedge clk);
        repeat (4) @(negedge clk);
        if (bad(grant.valid !== 1'b0)) miss("disabled source granted");
        if (bad(got.size() != exp_q.size())) miss("grant count");
        for (n = 0; n < exp_q.size() && n < got.size(); n++) begin
            if (bad(got[n] !== exp_q[n])) miss("grant order");
            if (bad(got_fetch[n] !== vip_addr_t'(base_exp + {got[n], 1'b0}))) miss("fetch");
        end
        @(posedge clk);
        req <= '0;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        miss("watchdog expired");
        test_done;
    end

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        ce = 1'b1;
        req = '0;
        cfg = '0;
        vector_base_wr = 1'b0;
        vector_base_wdata = '0;
        ack_wait = 4'h0;
        base_exp = '0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        start_and_freeze;
        load_base(19'h7fff0);
        run(pat(0, 3), 4'h0);
        run(pat(1, 4), 4'h5);
        test_done;
    end
endmodule // vip_top_tb
